// ### hdl/rps_regs.vh
// Register indices, field layout and reset values of the pin select unit
`ifndef RPS_REGS_VH
`define RPS_REGS_VH

// ****************************************************************
// Bus geometry
// ****************************************************************
`define RPS_ADDR_W 4
`define RPS_DATA_W 16
`define RPS_DATA_ZERO 16'h0000

// ****************************************************************
// Register indices on the register port
// ****************************************************************
`define RPS_IDX_UART3_SPI1 4'h0
`define RPS_IDX_SPI2_CLK_DATA 4'h1
`define RPS_IDX_TIMER_SPI2_SS 4'h2
`define RPS_IDX_UART4 4'h3
`define RPS_IDX_MOD_IN 4'h4
`define RPS_IDX_MOD_CARRIER 4'h5
`define RPS_IDX_PIN0_PIN1 4'h6
`define RPS_IDX_PIN2_PIN3 4'h7

// ****************************************************************
// Field layout
// ****************************************************************
`define RPS_FIELD_W 6
`define RPS_HI_MSB 13
`define RPS_HI_LSB 8
`define RPS_LO_MSB 5
`define RPS_LO_LSB 0
`define RPS_MASK_PAIR 16'h3f3f
`define RPS_MASK_LOW 16'h003f

// ****************************************************************
// Reset values
// ****************************************************************
`define RPS_RESET_IN_PAIR 16'h3f3f
`define RPS_RESET_IN_LOW 16'h003f
`define RPS_RESET_OUT 16'h0000

// ****************************************************************
// Pins and peripheral outputs
// ****************************************************************
`define RPS_PIN_COUNT 64
`define RPS_OUT_PINS 4
`define RPS_PERIPH_COUNT 64
`define RPS_NO_OUTPUT 6'h00

`endif

// ### hdl/rps_pin_sync.v
// Three-stage synchroniser with agreement filter for one pin input
`include "rps_regs.vh"

module rps_pin_sync (
	input wire i_clk,
	input wire i_reset,
	input wire i_pin,
	output reg o_level_r
);

	reg stage1_r;
	reg stage2_r;
	reg stage3_r;

	// ****************************************************************
	// Synchroniser chain
	// ****************************************************************
	always @(posedge i_clk) begin
		if (i_reset) begin
			stage1_r <= 1'b0;
			stage2_r <= 1'b0;
			stage3_r <= 1'b0;
		end else begin
			stage1_r <= i_pin;
			stage2_r <= stage1_r;
			stage3_r <= stage2_r;
		end
	end

	// ****************************************************************
	// Agreement filter
	// ****************************************************************
	// Change accepted only when stages two and three agree
	always @(posedge i_clk) begin
		if (i_reset) begin
			o_level_r <= 1'b0;
		end else if (stage2_r == stage3_r) begin
			o_level_r <= stage3_r;
		end
	end

endmodule // rps_pin_sync

// ### hdl/rps_out_drive.v
// Output driver of one remappable pin, fed by a peripheral output select
`include "rps_regs.vh"

module rps_out_drive (
	input wire i_clk,
	input wire i_reset,
	input wire [`RPS_FIELD_W-1:0] i_sel,
	input wire [`RPS_PERIPH_COUNT-1:0] i_periph,
	output reg o_pin_r,
	output reg o_oe_r
);

	// ****************************************************************
	// Registered pin drive
	// ****************************************************************
	// Select zero releases the pin to its port function
	always @(posedge i_clk) begin
		if (i_reset) begin
			o_pin_r <= 1'b0;
			o_oe_r <= 1'b0;
		end else if (i_sel == `RPS_NO_OUTPUT) begin
			o_pin_r <= 1'b0;
			o_oe_r <= 1'b0;
		end else begin
			o_pin_r <= i_periph[i_sel];
			o_oe_r <= 1'b1;
		end
	end

endmodule // rps_out_drive

// ### hdl/rps_top.v
// Remappable pin select registers with input routing and output mapping
//
// Added by the designer: the plain strobed port and the register addresses.
`include "rps_regs.vh"

module rps_top (
	input wire i_clk,
	input wire i_reset,
	input wire [`RPS_ADDR_W-1:0] i_addr,
	input wire [`RPS_DATA_W-1:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output reg [`RPS_DATA_W-1:0] o_rdata,
	input wire [`RPS_PIN_COUNT-1:0] i_remappable_io_pin,
	input wire [`RPS_PERIPH_COUNT-1:0] i_periph_out,
	output wire [`RPS_OUT_PINS-1:0] o_remappable_io_pin_out,
	output wire [`RPS_OUT_PINS-1:0] o_remappable_io_pin_oe,
	output reg o_uart3_clear_to_send_in,
	output reg o_spi1_slave_select_in,
	output reg o_spi2_clock_in,
	output reg o_spi2_data_in,
	output reg o_timer_ext_clock_in,
	output reg o_spi2_slave_select_in,
	output reg o_uart4_clear_to_send_in,
	output reg o_uart4_receive_in,
	output reg o_modulator_modulation_in,
	output reg o_modulator_carrier_one_in,
	output reg o_modulator_carrier_two_in
);

	// ****************************************************************
	// Configuration registers
	// ****************************************************************
	reg [`RPS_DATA_W-1:0] uart3_cts_spi1_ss_input_select_r;
	reg [`RPS_DATA_W-1:0] spi2_clock_data_input_select_r;
	reg [`RPS_DATA_W-1:0] timer_clock_spi2_ss_input_select_r;
	reg [`RPS_DATA_W-1:0] uart4_input_select_r;
	reg [`RPS_DATA_W-1:0] modulator_input_select_r;
	reg [`RPS_DATA_W-1:0] modulator_carrier_input_select_r;
	reg [`RPS_DATA_W-1:0] pin0_pin1_output_map_r;
	reg [`RPS_DATA_W-1:0] pin2_pin3_output_map_r;
	reg [`RPS_DATA_W-1:0] rdata_nxt;

	// Filtered pin levels after synchronisation
	wire [`RPS_PIN_COUNT-1:0] pin_level;

	// ****************************************************************
	// Field extraction
	// ****************************************************************
	// UART3 clear-to-send and SPI1 slave select selections
	wire [`RPS_FIELD_W-1:0] uart3_cts_pin_sel;
	wire [`RPS_FIELD_W-1:0] spi1_ss_pin_sel;
	assign uart3_cts_pin_sel =
		uart3_cts_spi1_ss_input_select_r[`RPS_HI_MSB:`RPS_HI_LSB];
	assign spi1_ss_pin_sel =
		uart3_cts_spi1_ss_input_select_r[`RPS_LO_MSB:`RPS_LO_LSB];

	// SPI2 clock and data selections
	wire [`RPS_FIELD_W-1:0] spi2_clock_pin_sel;
	wire [`RPS_FIELD_W-1:0] spi2_data_pin_sel;
	assign spi2_clock_pin_sel =
		spi2_clock_data_input_select_r[`RPS_HI_MSB:`RPS_HI_LSB];
	assign spi2_data_pin_sel =
		spi2_clock_data_input_select_r[`RPS_LO_MSB:`RPS_LO_LSB];

	// Timer clock and SPI2 slave select selections
	wire [`RPS_FIELD_W-1:0] timer_clock_pin_sel;
	wire [`RPS_FIELD_W-1:0] spi2_ss_pin_sel;
	assign timer_clock_pin_sel =
		timer_clock_spi2_ss_input_select_r[`RPS_HI_MSB:`RPS_HI_LSB];
	assign spi2_ss_pin_sel =
		timer_clock_spi2_ss_input_select_r[`RPS_LO_MSB:`RPS_LO_LSB];

	// UART4 clear-to-send and receive selections
	wire [`RPS_FIELD_W-1:0] uart4_cts_pin_sel;
	wire [`RPS_FIELD_W-1:0] uart4_rx_pin_sel;
	assign uart4_cts_pin_sel = uart4_input_select_r[`RPS_HI_MSB:`RPS_HI_LSB];
	assign uart4_rx_pin_sel = uart4_input_select_r[`RPS_LO_MSB:`RPS_LO_LSB];

	// Modulator modulation selection, low field only
	wire [`RPS_FIELD_W-1:0] modulation_pin_sel;
	assign modulation_pin_sel = modulator_input_select_r[`RPS_LO_MSB:`RPS_LO_LSB];

	// Modulator carrier selections
	wire [`RPS_FIELD_W-1:0] carrier_one_pin_sel;
	wire [`RPS_FIELD_W-1:0] carrier_two_pin_sel;
	assign carrier_one_pin_sel =
		modulator_carrier_input_select_r[`RPS_LO_MSB:`RPS_LO_LSB];
	assign carrier_two_pin_sel =
		modulator_carrier_input_select_r[`RPS_HI_MSB:`RPS_HI_LSB];

	// Output selections, packed per pin for the driver loop
	wire [`RPS_FIELD_W-1:0] pin0_output_sel;
	wire [`RPS_FIELD_W-1:0] pin1_output_sel;
	wire [`RPS_FIELD_W-1:0] pin2_output_sel;
	wire [`RPS_FIELD_W-1:0] pin3_output_sel;
	wire [`RPS_OUT_PINS*`RPS_FIELD_W-1:0] output_sel_bus;
	assign pin0_output_sel = pin0_pin1_output_map_r[`RPS_LO_MSB:`RPS_LO_LSB];
	assign pin1_output_sel = pin0_pin1_output_map_r[`RPS_HI_MSB:`RPS_HI_LSB];
	assign pin2_output_sel = pin2_pin3_output_map_r[`RPS_LO_MSB:`RPS_LO_LSB];
	assign pin3_output_sel = pin2_pin3_output_map_r[`RPS_HI_MSB:`RPS_HI_LSB];
	assign output_sel_bus = {pin3_output_sel, pin2_output_sel,
		pin1_output_sel, pin0_output_sel};

	// ****************************************************************
	// Write decode
	// ****************************************************************
	// Input selection registers, one strobe each
	wire wr_uart3_spi1;
	wire wr_spi2_clk_data;
	wire wr_timer_spi2_ss;
	wire wr_uart4;
	wire wr_mod_in;
	wire wr_mod_carrier;
	assign wr_uart3_spi1 =
		i_wr && (i_addr == `RPS_IDX_UART3_SPI1);
	assign wr_spi2_clk_data =
		i_wr && (i_addr == `RPS_IDX_SPI2_CLK_DATA);
	assign wr_timer_spi2_ss =
		i_wr && (i_addr == `RPS_IDX_TIMER_SPI2_SS);
	assign wr_uart4 =
		i_wr && (i_addr == `RPS_IDX_UART4);
	assign wr_mod_in =
		i_wr && (i_addr == `RPS_IDX_MOD_IN);
	assign wr_mod_carrier =
		i_wr && (i_addr == `RPS_IDX_MOD_CARRIER);

	// Output mapping registers; an unmapped index matches no strobe
	wire wr_pin0_pin1;
	wire wr_pin2_pin3;
	assign wr_pin0_pin1 =
		i_wr && (i_addr == `RPS_IDX_PIN0_PIN1);
	assign wr_pin2_pin3 =
		i_wr && (i_addr == `RPS_IDX_PIN2_PIN3);

	// Write data with the unimplemented bits already cleared
	wire [`RPS_DATA_W-1:0] wdata_pair;
	wire [`RPS_DATA_W-1:0] wdata_low;
	assign wdata_pair = i_wdata & `RPS_MASK_PAIR;
	assign wdata_low = i_wdata & `RPS_MASK_LOW;

	// ****************************************************************
	// Register writes
	// ****************************************************************
	// Unimplemented bits are masked off on every write
	always @(posedge i_clk) begin
		if (i_reset) begin
			uart3_cts_spi1_ss_input_select_r <= `RPS_RESET_IN_PAIR;
		end else if (wr_uart3_spi1) begin
			uart3_cts_spi1_ss_input_select_r <= wdata_pair;
		end
	end

	// SPI2 clock and data register
	always @(posedge i_clk) begin
		if (i_reset) begin
			spi2_clock_data_input_select_r <= `RPS_RESET_IN_PAIR;
		end else if (wr_spi2_clk_data) begin
			spi2_clock_data_input_select_r <= wdata_pair;
		end
	end

	// Timer clock and SPI2 slave select register
	always @(posedge i_clk) begin
		if (i_reset) begin
			timer_clock_spi2_ss_input_select_r <= `RPS_RESET_IN_PAIR;
		end else if (wr_timer_spi2_ss) begin
			timer_clock_spi2_ss_input_select_r <= wdata_pair;
		end
	end

	// UART4 register
	always @(posedge i_clk) begin
		if (i_reset) begin
			uart4_input_select_r <= `RPS_RESET_IN_PAIR;
		end else if (wr_uart4) begin
			uart4_input_select_r <= wdata_pair;
		end
	end

	// Modulator input register, upper ten bits never stored
	always @(posedge i_clk) begin
		if (i_reset) begin
			modulator_input_select_r <= `RPS_RESET_IN_LOW;
		end else if (wr_mod_in) begin
			modulator_input_select_r <= wdata_low;
		end
	end

	// Modulator carrier register
	always @(posedge i_clk) begin
		if (i_reset) begin
			modulator_carrier_input_select_r <= `RPS_RESET_IN_PAIR;
		end else if (wr_mod_carrier) begin
			modulator_carrier_input_select_r <= wdata_pair;
		end
	end

	// Output map for pins 0 and 1
	always @(posedge i_clk) begin
		if (i_reset) begin
			pin0_pin1_output_map_r <= `RPS_RESET_OUT;
		end else if (wr_pin0_pin1) begin
			pin0_pin1_output_map_r <= wdata_pair;
		end
	end

	// Output map for pins 2 and 3
	always @(posedge i_clk) begin
		if (i_reset) begin
			pin2_pin3_output_map_r <= `RPS_RESET_OUT;
		end else if (wr_pin2_pin3) begin
			pin2_pin3_output_map_r <= wdata_pair;
		end
	end

	// ****************************************************************
	// Register reads
	// ****************************************************************
	// Read mux; unmapped indices answer zero
	always @* begin
		case (i_addr)
			`RPS_IDX_UART3_SPI1: begin
				rdata_nxt = uart3_cts_spi1_ss_input_select_r;
			end
			`RPS_IDX_SPI2_CLK_DATA: begin
				rdata_nxt = spi2_clock_data_input_select_r;
			end
			`RPS_IDX_TIMER_SPI2_SS: begin
				rdata_nxt = timer_clock_spi2_ss_input_select_r;
			end
			`RPS_IDX_UART4: begin
				rdata_nxt = uart4_input_select_r;
			end
			`RPS_IDX_MOD_IN: begin
				rdata_nxt = modulator_input_select_r;
			end
			`RPS_IDX_MOD_CARRIER: begin
				rdata_nxt = modulator_carrier_input_select_r;
			end
			`RPS_IDX_PIN0_PIN1: begin
				rdata_nxt = pin0_pin1_output_map_r;
			end
			`RPS_IDX_PIN2_PIN3: begin
				rdata_nxt = pin2_pin3_output_map_r;
			end
			default: begin
				rdata_nxt = `RPS_DATA_ZERO;
			end
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always @(posedge i_clk) begin
		if (i_reset) begin
			o_rdata <= `RPS_DATA_ZERO;
		end else if (i_rd) begin
			o_rdata <= rdata_nxt;
		end else begin
			o_rdata <= `RPS_DATA_ZERO;
		end
	end

	// ****************************************************************
	// Pin input synchronisers
	// ****************************************************************
	// Every remappable pin is filtered once, shared by all selectors
	genvar pin_idx;
	generate
		for (pin_idx = 0; pin_idx < `RPS_PIN_COUNT; pin_idx = pin_idx + 1) begin : g_pin_sync
			rps_pin_sync u_sync (
				.i_clk(i_clk),
				.i_reset(i_reset),
				.i_pin(i_remappable_io_pin[pin_idx]),
				.o_level_r(pin_level[pin_idx])
			);
		end
	endgenerate

	// ****************************************************************
	// Peripheral input routing
	// ****************************************************************
	// Registered selection of a filtered pin for each peripheral input
	always @(posedge i_clk) begin
		if (i_reset) begin
			o_uart3_clear_to_send_in <= 1'b0;
			o_spi1_slave_select_in <= 1'b0;
			o_spi2_clock_in <= 1'b0;
			o_spi2_data_in <= 1'b0;
			o_timer_ext_clock_in <= 1'b0;
			o_spi2_slave_select_in <= 1'b0;
			o_uart4_clear_to_send_in <= 1'b0;
			o_uart4_receive_in <= 1'b0;
			o_modulator_modulation_in <= 1'b0;
			o_modulator_carrier_one_in <= 1'b0;
			o_modulator_carrier_two_in <= 1'b0;
		end else begin
			o_uart3_clear_to_send_in <= pin_level[uart3_cts_pin_sel];
			o_spi1_slave_select_in <= pin_level[spi1_ss_pin_sel];
			o_spi2_clock_in <= pin_level[spi2_clock_pin_sel];
			o_spi2_data_in <= pin_level[spi2_data_pin_sel];
			o_timer_ext_clock_in <= pin_level[timer_clock_pin_sel];
			o_spi2_slave_select_in <= pin_level[spi2_ss_pin_sel];
			o_uart4_clear_to_send_in <= pin_level[uart4_cts_pin_sel];
			o_uart4_receive_in <= pin_level[uart4_rx_pin_sel];
			o_modulator_modulation_in <= pin_level[modulation_pin_sel];
			o_modulator_carrier_one_in <= pin_level[carrier_one_pin_sel];
			o_modulator_carrier_two_in <= pin_level[carrier_two_pin_sel];
		end
	end

	// ****************************************************************
	// Remappable pin output drivers
	// ****************************************************************
	// One driver per mapped pin; peripheral outputs share this clock
	genvar out_idx;
	generate
		for (out_idx = 0; out_idx < `RPS_OUT_PINS; out_idx = out_idx + 1) begin : g_out_drive
			rps_out_drive u_drive (
				.i_clk(i_clk),
				.i_reset(i_reset),
				.i_sel(output_sel_bus[out_idx*`RPS_FIELD_W +: `RPS_FIELD_W]),
				.i_periph(i_periph_out),
				.o_pin_r(o_remappable_io_pin_out[out_idx]),
				.o_oe_r(o_remappable_io_pin_oe[out_idx])
			);
		end
	endgenerate

endmodule // rps_top

// ### sim/rps_top_sva.sv
// Port checker for the pin select unit
`include "rps_regs.vh"

module rps_sva (
	input wire i_clk,
	input wire i_reset,
	input wire [`RPS_ADDR_W-1:0] i_addr,
	input wire [`RPS_DATA_W-1:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	input wire [`RPS_DATA_W-1:0] o_rdata,
	input wire [`RPS_PERIPH_COUNT-1:0] i_periph_out,
	input wire [`RPS_OUT_PINS-1:0] o_remappable_io_pin_out,
	input wire [`RPS_OUT_PINS-1:0] o_remappable_io_pin_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] sel_r [0:3];
	logic [3:0] want_oe;
	logic [3:0] want_out;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	// Shadow of the output map fields
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			for (int k = 0; k < 4; k++) sel_r[k] <= 6'h00;
		end else if (i_wr && i_addr == 4'h6) begin
			sel_r[0] <= i_wdata[5:0];
			sel_r[1] <= i_wdata[13:8];
		end else if (i_wr && i_addr == 4'h7) begin
			sel_r[2] <= i_wdata[5:0];
			sel_r[3] <= i_wdata[13:8];
		end
	end

	// Expected pin drive from the shadow
	always_comb begin
		for (int k = 0; k < 4; k++) begin
			want_oe[k] = sel_r[k] != 6'h00;
			want_out[k] = want_oe[k] & i_periph_out[sel_r[k]];
		end
	end

	a_unimpl_bits_zero: assert property (i_rd |=> (o_rdata & 16'hc0c0) == 16'h0000)
		else $error("reserved read bits set");
	a_mod_upper_zero: assert property (i_rd && i_addr == 4'h4 |=> o_rdata[15:6] == 10'h000)
		else $error("modulator upper bits set");
	a_in_write_back: assert property ((i_wr && i_addr < 4'h4) ##1 (i_rd && i_addr == $past(i_addr))
		|=> o_rdata == ($past(i_wdata, 2) & `RPS_MASK_PAIR))
		else $error("input select readback wrong");
	a_map_lo_read: assert property (i_rd && i_addr == 4'h6
		|=> o_rdata == {2'b00, sel_r[1], 2'b00, sel_r[0]})
		else $error("pin0 pin1 map readback wrong");
	a_map_hi_read: assert property (i_rd && i_addr == 4'h7
		|=> o_rdata == {2'b00, sel_r[3], 2'b00, sel_r[2]})
		else $error("pin2 pin3 map readback wrong");
	a_pin_oe_map: assert property (o_remappable_io_pin_oe == $past(want_oe))
		else $error("pin enable does not follow map");
	a_pin_out_map: assert property (o_remappable_io_pin_out == $past(want_out))
		else $error("pin value does not follow map");
	a_free_pin_low: assert property ((o_remappable_io_pin_out & ~o_remappable_io_pin_oe) == 4'h0)
		else $error("released pin drives high");
endmodule // rps_sva

bind rps_top rps_sva u_rps_sva (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_periph_out(i_periph_out),
	.o_remappable_io_pin_out(o_remappable_io_pin_out),
	.o_remappable_io_pin_oe(o_remappable_io_pin_oe));

// ### sim/tb_rps_top.sv
// Self-checking bench for the pin select unit
`include "rps_regs.vh"

module tb_rps_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk = 1'b0;
	logic i_reset = 1'b1;
	logic [3:0] i_addr = 4'h0;
	logic [15:0] i_wdata = 16'h0000;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [63:0] i_pin = 64'h0;
	logic [63:0] i_periph = 64'h0;
	wire [15:0] o_rdata;
	wire [3:0] pin_out;
	wire [3:0] pin_oe;
	wire [10:0] routed;
	int n_mismatch = 0;
	int check_count = 0;
	int cyc = 0;
	logic rd_due = 1'b0;
	logic [15:0] rd_exp = 16'h0000;
	logic [15:0] rd_want = 16'h0000;
	logic [5:0] f [0:10];
	logic [15:0] rv [0:8] = '{16'h3f3f, 16'h3f3f, 16'h3f3f, 16'h3f3f, 16'h003f, 16'h3f3f,
		16'h0000, 16'h0000, 16'h0000};
	logic [15:0] mk [0:8] = '{16'h3f3f, 16'h3f3f, 16'h3f3f, 16'h3f3f, 16'h003f, 16'h3f3f,
		16'h3f3f, 16'h3f3f, 16'h0000};

	rps_top u_rps_top (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_remappable_io_pin(i_pin),
		.i_periph_out(i_periph), .o_remappable_io_pin_out(pin_out),
		.o_remappable_io_pin_oe(pin_oe), .o_uart3_clear_to_send_in(routed[0]),
		.o_spi1_slave_select_in(routed[1]), .o_spi2_clock_in(routed[2]),
		.o_spi2_data_in(routed[3]), .o_timer_ext_clock_in(routed[4]),
		.o_spi2_slave_select_in(routed[5]), .o_uart4_clear_to_send_in(routed[6]),
		.o_uart4_receive_in(routed[7]), .o_modulator_modulation_in(routed[8]),
		.o_modulator_carrier_one_in(routed[9]), .o_modulator_carrier_two_in(routed[10]));

	// ****************************************************************
	// Clock, hang guard and report
	// ****************************************************************
	always #10 i_clk = ~i_clk;

	// Cut a hang short
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_mismatch++;
			results();
		end
	end

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// ****************************************************************
	// Compare and bus tasks
	// ****************************************************************
	task automatic chk_reg(input logic [15:0] g, input logic [15:0] e);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("FAIL %0t read %h want %h", $time, g, e);
		end
	endtask

	task automatic chk_sig(input logic [15:0] g, input logic [15:0] e);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("FAIL %0t pins %h want %h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		i_wr <= 1'b1;
		i_rd <= 1'b0;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
	endtask

	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		i_rd <= 1'b1;
		i_wr <= 1'b0;
		i_addr <= a;
		rd_exp <= e;
		@(posedge i_clk);
	endtask

	// Read data stands only in the cycle after the strobe; track that cycle
	always @(posedge i_clk) begin
		rd_due <= i_rd;
		rd_want <= rd_exp;
	end

	// Compare mid-cycle, while the read data stand
	always @(negedge i_clk) begin
		if (rd_due) begin
			chk_reg(o_rdata, rd_want);
		end
	end

	task automatic idle(input int n);
		i_wr <= 1'b0;
		i_rd <= 1'b0;
		repeat (n) @(posedge i_clk);
	endtask

	task automatic rst();
		i_reset <= 1'b1;
		idle(20);
		i_reset <= 1'b0;
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		for (int k = 0; k < 11; k++) f[k] = 6'(5 * k + 3);
		rst();
		for (int a = 0; a < 9; a++) rd(4'(a), rv[a]);
		chk_sig({12'h000, pin_oe}, 16'h0000);
		// All input selects point at the top pin after reset
		i_pin <= 64'h8000_0000_0000_0000;
		idle(6);
		chk_sig({5'h00, routed}, 16'h07ff);
		// Back-to-back write and read, all ones then zero
		for (int a = 0; a < 9; a++) begin
			wr(4'(a), 16'hffff);
			rd(4'(a), mk[a]);
			wr(4'(a), 16'h0000);
			rd(4'(a), 16'h0000);
		end
		// Route a distinct pin to every peripheral input
		for (int r = 0; r < 4; r++) begin
			wr(4'(r), {2'b00, f[2 * r], 2'b00, f[2 * r + 1]});
		end
		wr(4'h4, {10'h000, f[8]});
		wr(4'h5, {2'b00, f[10], 2'b00, f[9]});
		for (int k = 0; k < 11; k++) begin
			i_pin <= 64'h1 << f[k];
			idle(6);
			chk_sig({5'h00, routed}, 16'h1 << k);
		end
		// Output map: pin0 from 5, pin1 from 63, pin2 free, pin3 from 1
		i_periph <= 64'h8000_0000_0000_0020;
		wr(4'h6, 16'h3f05);
		wr(4'h7, 16'h0100);
		idle(2);
		chk_sig({12'h000, pin_oe}, 16'h000b);
		chk_sig({12'h000, pin_out}, 16'h0003);
		i_periph <= 64'h7fff_ffff_ffff_ffdf;
		idle(2);
		chk_sig({12'h000, pin_out}, 16'h0008);
		// Second reset in mid-run
		rst();
		rd(4'h0, 16'h3f3f);
		rd(4'h6, 16'h0000);
		chk_sig({12'h000, pin_oe}, 16'h0000);
		idle(1);
		results();
	end
endmodule // tb_rps_top
